/* File: hdl/ufc_flow_ctrl.sv */
// flow control unit for one uart channel: auto rts/cts and xon/xoff
// assumes rx_push comes after the first stop bit and the transmitter
// samples tx_allow only at character boundaries
//
// Summary of operation
// R01 - auto rts enabled drives rts_n low while the receiver can take data
// R02 - rts_n goes high once receive occupancy exceeds the upper threshold
// R03 - rts_n stays high until occupancy equals the lower threshold
// R04 - 64-byte mode upper threshold from fifo control bits 7:6: 8,16,56,60
// R05 - 64-byte mode lower threshold from fifo control bits 5:4: 0,8,16,56
// R06 - software keeps programmed upper threshold above lower threshold
// R07 - flow status bit 5 mirrors the rts_n level under auto rts
// R08 - rts_n rising under auto rts raises an interrupt when enabled
// R09 - reading the modem status register clears the rts interrupt
// R10 - rts_n rises after the stop bit of the crossing character
// R11 - feature bit 7 enables auto cts gating of transmission
// R12 - cts_n low sends fifo data, high holds off new characters
// R13 - a character already being shifted out always completes
// R14 - flow status bit 1 shows cts_n level under auto cts
// R15 - cts_n rising raises an interrupt when enabled; modem read clears
// R16 - transmit flow control sends xoff when occupancy exceeds upper
// R17 - after xoff, xon is sent when occupancy reaches the lower threshold
// R18 - receive flow control stops on xoff and resumes on xon
// R19 - transmit mode: 00 none, 10 pair one, 01 pair two, 11 both
// R20 - receive mode: 00 none, 10 pair one, 01 pair two, 11 sequences
// R21 - without flow control a push into a full fifo flags overrun
// R22 - fifo enable plus alternate bit selects 256-byte mode, fifo enable alone 64, fifo disabled 1
// R23 - a character arriving at a full receive fifo is discarded
// R24 - flow status bit 0 shows received xoff state
// R25 - occupancy counts every push into and pop from the receive fifo; code ignores pushes when full and pops when empty
// R26 - a pending xon/xoff goes out at the next boundary before data
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ufc_flow_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rx_push,
   input wire logic rx_pop,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic cts_n,
   input wire logic xchar_ready,
   output logic rts_n,
   output logic tx_allow,
   output logic xchar_valid,
   output logic [7:0] xchar_data,
   output logic rx_char_flow,
   output logic rx_discard,
   output logic rx_overrun,
   output logic irq
);

   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {UFC_R_IDLE, UFC_R_ON1, UFC_R_OFF1} ufc_rx_state_type;
   ufc_pkg::ufc_efr_type enhanced_feature_reg;
   ufc_pkg::ufc_chars_type chars_reg;
   logic [7:0] fifo_control_reg, alternate_function_reg, upper_threshold_reg;
   logic [7:0] lower_threshold_reg, interrupt_enable_reg;
   logic [8:0] rx_count_reg;
   logic rts_n_reg, cts_q_reg, tx_allow_reg, tx_xoff_reg, rx_xoff_reg;
   logic rts_pend_reg, cts_pend_reg, xoff_pend_reg, irq_reg;
   logic xchar_valid_reg, second_reg, second_off_reg;
   logic [7:0] xchar_data_reg;
   logic rx_char_flow_reg, rx_discard_reg, rx_overrun_reg;
   logic wr_rdy_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   ufc_rx_state_type rx_state_reg;

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic [7:0] pick_char(input logic [1:0] mode, input logic off,
                                            input logic second, input ufc_pkg::ufc_chars_type c);
      logic use2;
      use2 = (mode == ufc_pkg::UFC_MODE_P2) || ((mode == ufc_pkg::UFC_MODE_BOTH) && second);
      if (off) begin
         pick_char = use2 ? c.xoff2 : c.xoff1;
      end else begin
         pick_char = use2 ? c.xon2 : c.xon1;
      end
   endfunction

   function automatic logic [7:0] lut4(input logic [1:0] code, input logic [7:0] v0,
                                       input logic [7:0] v1, input logic [7:0] v2, input logic [7:0] v3);
      unique case (code)
         2'h0: lut4 = v0;
         2'h1: lut4 = v1;
         2'h2: lut4 = v2;
         2'h3: lut4 = v3;
      endcase
   endfunction

   logic mode256, fifo_full, push_ok, pop_ok, above_up, at_lo, no_flow, rx_sw, wr_go, rd_go;
   logic [7:0] up_thr, lo_thr, ch;
   logic [8:0] depth;
   assign mode256 = fifo_control_reg[ufc_pkg::UFC_FCR_EN] & alternate_function_reg[ufc_pkg::UFC_AFR_256]; // R22
   assign depth = !fifo_control_reg[ufc_pkg::UFC_FCR_EN] ? ufc_pkg::UFC_DEPTH1 :
                  (mode256 ? ufc_pkg::UFC_DEPTH256 : ufc_pkg::UFC_DEPTH64); // R22
   assign up_thr = mode256 ? upper_threshold_reg : lut4(fifo_control_reg[ufc_pkg::UFC_FCR_UP_LSB +: 2],
      ufc_pkg::UFC_UP0, ufc_pkg::UFC_UP1, ufc_pkg::UFC_UP2, ufc_pkg::UFC_UP3); // R04 R06
   assign lo_thr = mode256 ? lower_threshold_reg : lut4(fifo_control_reg[ufc_pkg::UFC_FCR_LO_LSB +: 2],
      ufc_pkg::UFC_LO0, ufc_pkg::UFC_LO1, ufc_pkg::UFC_LO2, ufc_pkg::UFC_LO3); // R05
   assign fifo_full = rx_count_reg >= depth;
   assign push_ok = rx_push & ~fifo_full;
   assign pop_ok = rx_pop & (rx_count_reg != 9'h000);
   assign above_up = rx_count_reg > {1'b0, up_thr};
   assign at_lo = rx_count_reg == {1'b0, lo_thr};
   assign no_flow = ~enhanced_feature_reg.rts_auto & (enhanced_feature_reg.tx_mode == ufc_pkg::UFC_MODE_OFF);
   assign rx_sw = enhanced_feature_reg.rx_mode != ufc_pkg::UFC_MODE_OFF;
   assign wr_go = wr_rdy_reg & awvalid & wvalid;
   assign rd_go = arready_reg & arvalid;
   assign ch = rx_char;

   // ****************************************
   // axi4-lite slave
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_rdy_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= ufc_pkg::UFC_RESP_OKAY;
      end else begin
         wr_rdy_reg <= ~wr_rdy_reg & awvalid & wvalid & ~bvalid_reg;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (awaddr > ufc_pkg::UFC_RCR_OFS || awaddr[1:0] != 2'h0) ?
                         ufc_pkg::UFC_RESP_SLVERR : ufc_pkg::UFC_RESP_OKAY;
         end else if (bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= ufc_pkg::UFC_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         arready_reg <= ~arready_reg & arvalid & ~rvalid_reg;
         if (rd_go) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= ufc_pkg::UFC_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            unique case (araddr)
               ufc_pkg::UFC_EFR_OFS: rdata_reg[7:0] <= enhanced_feature_reg;
               ufc_pkg::UFC_FCR_OFS: rdata_reg[7:0] <= fifo_control_reg;
               ufc_pkg::UFC_AFR_OFS: rdata_reg[7:0] <= alternate_function_reg;
               ufc_pkg::UFC_FUR_OFS: rdata_reg[7:0] <= up_thr;
               ufc_pkg::UFC_FLR_OFS: rdata_reg[7:0] <= lo_thr;
               ufc_pkg::UFC_IER_OFS: rdata_reg[7:0] <= interrupt_enable_reg;
               ufc_pkg::UFC_XON1_OFS: rdata_reg[7:0] <= chars_reg.xon1;
               ufc_pkg::UFC_XON2_OFS: rdata_reg[7:0] <= chars_reg.xon2;
               ufc_pkg::UFC_XOFF1_OFS: rdata_reg[7:0] <= chars_reg.xoff1;
               ufc_pkg::UFC_XOFF2_OFS: rdata_reg[7:0] <= chars_reg.xoff2;
               ufc_pkg::UFC_FSR_OFS: begin
                  rdata_reg[ufc_pkg::UFC_FSR_RTS] <= enhanced_feature_reg.rts_auto & rts_n_reg; // R07
                  rdata_reg[ufc_pkg::UFC_FSR_TXOFF] <= tx_xoff_reg;
                  rdata_reg[ufc_pkg::UFC_FSR_CTS] <= enhanced_feature_reg.cts_auto & cts_q_reg; // R14
                  rdata_reg[ufc_pkg::UFC_FSR_RXOFF] <= rx_sw & rx_xoff_reg; // R24
               end
               ufc_pkg::UFC_ISR_OFS: rdata_reg[5:0] <= (rts_pend_reg | cts_pend_reg) ? ufc_pkg::UFC_ISR_MODEM :
                  (xoff_pend_reg ? ufc_pkg::UFC_ISR_XOFF : ufc_pkg::UFC_ISR_NONE);
               ufc_pkg::UFC_MSR_OFS: rdata_reg[ufc_pkg::UFC_MSR_CTS] <= ~cts_q_reg;
               ufc_pkg::UFC_RCR_OFS: rdata_reg[8:0] <= rx_count_reg;
               default: rresp_reg <= ufc_pkg::UFC_RESP_SLVERR;
            endcase
         end else if (rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // software registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enhanced_feature_reg <= ufc_pkg::UFC_REG_RST;
         fifo_control_reg <= ufc_pkg::UFC_REG_RST;
         alternate_function_reg <= ufc_pkg::UFC_REG_RST;
         upper_threshold_reg <= ufc_pkg::UFC_REG_RST;
         lower_threshold_reg <= ufc_pkg::UFC_REG_RST;
         interrupt_enable_reg <= ufc_pkg::UFC_REG_RST;
         chars_reg <= {4{ufc_pkg::UFC_REG_RST}};
      end else if (wr_go && wstrb[0]) begin
         unique case (awaddr)
            ufc_pkg::UFC_EFR_OFS: enhanced_feature_reg <= wdata[7:0]; // R11 R19 R20
            ufc_pkg::UFC_FCR_OFS: fifo_control_reg <= wdata[7:0];
            ufc_pkg::UFC_AFR_OFS: alternate_function_reg <= wdata[7:0];
            ufc_pkg::UFC_FUR_OFS: upper_threshold_reg <= wdata[7:0];
            ufc_pkg::UFC_FLR_OFS: lower_threshold_reg <= wdata[7:0];
            ufc_pkg::UFC_IER_OFS: interrupt_enable_reg <= wdata[7:0];
            ufc_pkg::UFC_XON1_OFS: chars_reg.xon1 <= wdata[7:0];
            ufc_pkg::UFC_XON2_OFS: chars_reg.xon2 <= wdata[7:0];
            ufc_pkg::UFC_XOFF1_OFS: chars_reg.xoff1 <= wdata[7:0];
            ufc_pkg::UFC_XOFF2_OFS: chars_reg.xoff2 <= wdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // receive occupancy and hardware flow
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_count_reg <= 9'h000;
         rx_discard_reg <= 1'b0;
         rx_overrun_reg <= 1'b0;
      end else begin
         rx_count_reg <= rx_count_reg + {8'h00, push_ok} - {8'h00, pop_ok}; // R25
         rx_discard_reg <= rx_push & fifo_full; // R23
         rx_overrun_reg <= rx_push & fifo_full & no_flow; // R21
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_n_reg <= 1'b0;
         cts_q_reg <= 1'b1;
         tx_allow_reg <= 1'b0;
      end else begin
         cts_q_reg <= cts_n;
         if (!enhanced_feature_reg.rts_auto) begin
            rts_n_reg <= 1'b0; // R01
         end else if (above_up) begin
            rts_n_reg <= 1'b1; // R02 R10
         end else if (at_lo) begin
            rts_n_reg <= 1'b0; // R03
         end
         tx_allow_reg <= ~(enhanced_feature_reg.cts_auto & cts_n) & ~(rx_sw & rx_xoff_reg); // R12 R13 R18
      end
   end

   // ****************************************
   // interrupts, cleared by status reads
   // ****************************************
   logic rts_rise, cts_rise, msr_rd, isr_rd, rx_xon_set, rx_xoff_set;
   assign rts_rise = enhanced_feature_reg.rts_auto & ~rts_n_reg & above_up;
   assign cts_rise = cts_n & ~cts_q_reg;
   assign msr_rd = rd_go & (araddr == ufc_pkg::UFC_MSR_OFS);
   assign isr_rd = rd_go & (araddr == ufc_pkg::UFC_ISR_OFS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts_pend_reg <= 1'b0;
         cts_pend_reg <= 1'b0;
         xoff_pend_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         if (rts_rise && interrupt_enable_reg[ufc_pkg::UFC_IER_RTS]) begin
            rts_pend_reg <= 1'b1; // R08
         end else if (msr_rd) begin
            rts_pend_reg <= 1'b0; // R09
         end
         if (cts_rise && enhanced_feature_reg.cts_auto && interrupt_enable_reg[ufc_pkg::UFC_IER_CTS]) begin
            cts_pend_reg <= 1'b1; // R15
         end else if (msr_rd) begin
            cts_pend_reg <= 1'b0; // R15
         end
         if (rx_xoff_set && interrupt_enable_reg[ufc_pkg::UFC_IER_XOFF]) begin
            xoff_pend_reg <= 1'b1;
         end else if (isr_rd || rx_xon_set) begin
            xoff_pend_reg <= 1'b0;
         end
         irq_reg <= rts_pend_reg | cts_pend_reg | xoff_pend_reg;
      end
   end

   // ****************************************
   // receive xon/xoff recognition
   // ****************************************
   logic [1:0] rm;
   assign rm = enhanced_feature_reg.rx_mode;
   always_comb begin
      rx_xon_set = 1'b0;
      rx_xoff_set = 1'b0;
      if (rx_char_valid && rx_sw) begin
         if (rm != ufc_pkg::UFC_MODE_BOTH) begin
            rx_xon_set = ch == pick_char(rm, 1'b0, 1'b0, chars_reg);
            rx_xoff_set = ~rx_xon_set & (ch == pick_char(rm, 1'b1, 1'b0, chars_reg));
         end else if (rx_state_reg == UFC_R_ON1) begin
            rx_xon_set = ch == chars_reg.xon2;
         end else if (rx_state_reg == UFC_R_OFF1) begin
            rx_xoff_set = ch == chars_reg.xoff2;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state_reg <= UFC_R_IDLE;
         rx_xoff_reg <= 1'b0;
         rx_char_flow_reg <= 1'b0;
      end else begin
         rx_char_flow_reg <= rx_xon_set | rx_xoff_set;
         if (!rx_sw || rx_xon_set) begin
            rx_xoff_reg <= 1'b0; // R18
         end else if (rx_xoff_set) begin
            rx_xoff_reg <= 1'b1; // R18 R24
         end
         if (rx_char_valid) begin
            if (rm != ufc_pkg::UFC_MODE_BOTH || rx_xon_set || rx_xoff_set) begin
               rx_state_reg <= UFC_R_IDLE; // R20
            end else if (ch == chars_reg.xon1) begin
               rx_state_reg <= UFC_R_ON1;
            end else if (ch == chars_reg.xoff1) begin
               rx_state_reg <= UFC_R_OFF1;
            end else begin
               rx_state_reg <= UFC_R_IDLE;
            end
         end
      end
   end

   // ****************************************
   // transmit xon/xoff insertion
   // ****************************************
   logic [1:0] tm;
   logic need_off, need_on;
   assign tm = enhanced_feature_reg.tx_mode;
   assign need_off = (tm != ufc_pkg::UFC_MODE_OFF) & ~tx_xoff_reg & above_up; // R16
   assign need_on = (tm != ufc_pkg::UFC_MODE_OFF) & tx_xoff_reg & at_lo; // R17

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_xoff_reg <= 1'b0;
         xchar_valid_reg <= 1'b0;
         xchar_data_reg <= 8'h00;
         second_reg <= 1'b0;
         second_off_reg <= 1'b0;
      end else if (xchar_valid_reg) begin
         if (xchar_ready) begin
            xchar_valid_reg <= second_reg; // R26
            second_reg <= 1'b0;
            xchar_data_reg <= pick_char(tm, second_off_reg, 1'b1, chars_reg); // R19
         end
      end else if (tm == ufc_pkg::UFC_MODE_OFF) begin
         tx_xoff_reg <= 1'b0;
      end else if (need_off || need_on) begin
         tx_xoff_reg <= need_off; // R16 R17
         xchar_valid_reg <= 1'b1; // R26
         xchar_data_reg <= pick_char(tm, need_off, 1'b0, chars_reg); // R19
         second_reg <= tm == ufc_pkg::UFC_MODE_BOTH;
         second_off_reg <= need_off;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign awready = wr_rdy_reg;
   assign wready = wr_rdy_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;
   assign rts_n = rts_n_reg;
   assign tx_allow = tx_allow_reg;
   assign xchar_valid = xchar_valid_reg;
   assign xchar_data = xchar_data_reg;
   assign rx_char_flow = rx_char_flow_reg;
   assign rx_discard = rx_discard_reg;
   assign rx_overrun = rx_overrun_reg;
   assign irq = irq_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking ufc_cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_first_off;
      xchar_valid_reg && xchar_ready && second_reg && second_off_reg;
   endsequence
   sequence s_second_off;
      xchar_valid_reg && xchar_data_reg == $past(chars_reg.xoff2);
   endsequence

   property p_rts_up;
      enhanced_feature_reg.rts_auto && above_up |=> rts_n_reg;
   endproperty
   a_rts_up: assert property (p_rts_up) else $error("rts_n not raised above upper"); // R02
   property p_rts_lo;
      enhanced_feature_reg.rts_auto && at_lo && !above_up |=> !rts_n_reg;
   endproperty
   a_rts_lo: assert property (p_rts_lo) else $error("rts_n not lowered at lower"); // R03
   property p_rts_hold;
      enhanced_feature_reg.rts_auto && !above_up && !at_lo |=> $stable(rts_n_reg);
   endproperty
   a_rts_hold: assert property (p_rts_hold) else $error("rts_n moved inside band"); // R03
   property p_cts_gate;
      enhanced_feature_reg.cts_auto && cts_n |=> !tx_allow_reg;
   endproperty
   a_cts_gate: assert property (p_cts_gate) else $error("sending while cts_n high"); // R12
   property p_cts_int;
      enhanced_feature_reg.cts_auto && interrupt_enable_reg[ufc_pkg::UFC_IER_CTS] && cts_n && !cts_q_reg
         |=> cts_pend_reg ##1 irq_reg;
   endproperty
   a_cts_int: assert property (p_cts_int) else $error("cts interrupt missing"); // R15
   property p_msr_clr;
      msr_rd && !rts_rise |=> !rts_pend_reg;
   endproperty
   a_msr_clr: assert property (p_msr_clr) else $error("modem read left rts pending"); // R09
   property p_overrun;
      rx_push && fifo_full && no_flow |=> rx_overrun_reg && rx_discard_reg &&
         rx_count_reg == $past(rx_count_reg) - {8'h00, $past(pop_ok)};
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R21
   property p_two_off;
      s_first_off |=> s_second_off;
   endproperty
   a_two_off: assert property (p_two_off) else $error("second xoff not sent"); // R19
   property p_rx_off;
      rx_xoff_set && !rx_xon_set |=> rx_xoff_reg ##1 !tx_allow_reg;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("xoff did not stop sending"); // R18

endmodule // ufc_flow_ctrl

/* File: hdl/ufc_pkg.sv */
// constants and types for the uart flow control unit
// assumes a single 100 MHz clock and a 32-bit AXI4-Lite register port
package ufc_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int UFC_AW = 8;
   localparam logic [7:0] UFC_EFR_OFS = 8'h00;
   localparam logic [7:0] UFC_FCR_OFS = 8'h04;
   localparam logic [7:0] UFC_AFR_OFS = 8'h08;
   localparam logic [7:0] UFC_FUR_OFS = 8'h0c;
   localparam logic [7:0] UFC_FLR_OFS = 8'h10;
   localparam logic [7:0] UFC_IER_OFS = 8'h14;
   localparam logic [7:0] UFC_XON1_OFS = 8'h18;
   localparam logic [7:0] UFC_XON2_OFS = 8'h1c;
   localparam logic [7:0] UFC_XOFF1_OFS = 8'h20;
   localparam logic [7:0] UFC_XOFF2_OFS = 8'h24;
   localparam logic [7:0] UFC_FSR_OFS = 8'h28;
   localparam logic [7:0] UFC_ISR_OFS = 8'h2c;
   localparam logic [7:0] UFC_MSR_OFS = 8'h30;
   localparam logic [7:0] UFC_RCR_OFS = 8'h34;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int UFC_FCR_EN = 0;
   localparam int UFC_FCR_UP_LSB = 6;
   localparam int UFC_FCR_LO_LSB = 4;
   localparam int UFC_AFR_256 = 0;
   localparam int UFC_IER_XOFF = 5;
   localparam int UFC_IER_RTS = 6;
   localparam int UFC_IER_CTS = 7;
   localparam int UFC_FSR_RTS = 5;
   localparam int UFC_FSR_TXOFF = 4;
   localparam int UFC_FSR_CTS = 1;
   localparam int UFC_FSR_RXOFF = 0;
   localparam int UFC_MSR_CTS = 4;
   localparam logic [7:0] UFC_REG_RST = 8'h00;

   // ****************************************
   // fifo depths and 64-byte mode thresholds
   // ****************************************
   localparam logic [8:0] UFC_DEPTH1 = 9'h001;
   localparam logic [8:0] UFC_DEPTH64 = 9'h040;
   localparam logic [8:0] UFC_DEPTH256 = 9'h100;
   localparam logic [7:0] UFC_UP0 = 8'h08;
   localparam logic [7:0] UFC_UP1 = 8'h10;
   localparam logic [7:0] UFC_UP2 = 8'h38;
   localparam logic [7:0] UFC_UP3 = 8'h3c;
   localparam logic [7:0] UFC_LO0 = 8'h00;
   localparam logic [7:0] UFC_LO1 = 8'h08;
   localparam logic [7:0] UFC_LO2 = 8'h10;
   localparam logic [7:0] UFC_LO3 = 8'h38;

   // ****************************************
   // interrupt codes and bus answers
   // ****************************************
   localparam logic [5:0] UFC_ISR_NONE = 6'h01;
   localparam logic [5:0] UFC_ISR_XOFF = 6'h10;
   localparam logic [5:0] UFC_ISR_MODEM = 6'h20;
   localparam logic [1:0] UFC_RESP_OKAY = 2'h0;
   localparam logic [1:0] UFC_RESP_SLVERR = 2'h2;
   localparam logic [1:0] UFC_MODE_OFF = 2'h0;
   localparam logic [1:0] UFC_MODE_P2 = 2'h1;
   localparam logic [1:0] UFC_MODE_P1 = 2'h2;
   localparam logic [1:0] UFC_MODE_BOTH = 2'h3;

   typedef struct packed {
      logic cts_auto;
      logic rts_auto;
      logic [1:0] spare;
      logic [1:0] tx_mode;
      logic [1:0] rx_mode;
   } ufc_efr_type;

   typedef struct packed {
      logic [7:0] xon1;
      logic [7:0] xon2;
      logic [7:0] xoff1;
      logic [7:0] xoff2;
   } ufc_chars_type;

endpackage

/* File: test/tb.sv */
// testbench for the uart flow control unit
// assumes the axi4-lite map and timings of ufc_pkg
`timescale 1ns/10ps
module tb;
   // ****************************************
   // signals and instances
   // ****************************************
   logic aclk=0, aresetn=0, awvalid=0, wvalid=0, bready=0, arvalid=0, rready=0, rx_push=0, rx_pop=0, cts_n=0;
   logic awready, wready, bvalid, arready, rvalid, xchar_ready, rts_n, tx_allow, xchar_valid;
   logic [7:0] awaddr=8'h00, araddr=8'h00, xchar_data, last_char;
   logic [31:0] wdata=32'h0, rdata, rv;
   logic [1:0] bresp, rresp, rr, br;
   logic rx_char_valid=0, irq, rx_char_flow, rx_discard, rx_overrun;
   logic [7:0] rx_char=8'h00;
   logic [2:0] seen=3'h0;
   logic [7:0] up[4] = '{ufc_pkg::UFC_UP0, ufc_pkg::UFC_UP1, ufc_pkg::UFC_UP2, ufc_pkg::UFC_UP3};
   logic [7:0] lo[4] = '{ufc_pkg::UFC_LO0, ufc_pkg::UFC_LO1, ufc_pkg::UFC_LO2, ufc_pkg::UFC_LO3};
   int n_fail=0, num_checks=0;
   always #5 aclk = ~aclk;
   ufc_flow_ctrl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rx_push(rx_push), .rx_pop(rx_pop), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .cts_n(cts_n), .xchar_ready(xchar_ready), .rts_n(rts_n), .tx_allow(tx_allow),
      .xchar_valid(xchar_valid), .xchar_data(xchar_data), .rx_char_flow(rx_char_flow), .rx_discard(rx_discard),
      .rx_overrun(rx_overrun), .irq(irq));
   ufc_remote far (.aclk(aclk), .xchar_valid(xchar_valid), .xchar_data(xchar_data), .xchar_ready(xchar_ready),
      .last_char(last_char));
   // one-cycle status pulses are kept and never cleared, so later checks see earlier ones too
   always @(posedge aclk) seen <= seen | {rx_char_flow, rx_overrun, rx_discard};
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0; wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      br = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rv = rdata; rr = rresp;
   endtask
   task automatic pulse(input int n, input logic pop);
      repeat (n) begin
         if (pop) rx_pop <= 1'b1; else rx_push <= 1'b1;
         @(posedge aclk);
      end
      rx_pop <= 1'b0; rx_push <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic thresholds;
      for (int i = 0; i < 4; i++) begin
         wr(ufc_pkg::UFC_FCR_OFS, {i[1:0], i[1:0], 4'h1});
         rd(ufc_pkg::UFC_FUR_OFS); chk(rv, {24'h0, up[i]});
         rd(ufc_pkg::UFC_FLR_OFS); chk(rv, {24'h0, lo[i]});
      end
      rd(8'h3c); chk(rr, ufc_pkg::UFC_RESP_SLVERR);
      wr(8'h3c, 8'h00); chk(br, ufc_pkg::UFC_RESP_SLVERR);
      wr(ufc_pkg::UFC_AFR_OFS, 8'h01); wr(ufc_pkg::UFC_FUR_OFS, 8'h08);
      rd(ufc_pkg::UFC_FUR_OFS); chk(rv, 32'h08);
   endtask
   task automatic auto_rts;
      wr(ufc_pkg::UFC_IER_OFS, 8'hc0);
      wr(ufc_pkg::UFC_FCR_OFS, 8'h01); wr(ufc_pkg::UFC_EFR_OFS, 8'h40);
      chk(rts_n, 1'b0);
      pulse(8, 1'b0); chk(rts_n, 1'b0);
      pulse(1, 1'b0); chk(rts_n, 1'b1);
      chk(irq, 1'b1);
      rd(ufc_pkg::UFC_FSR_OFS); chk(rv[5], 1'b1);
      rd(ufc_pkg::UFC_MSR_OFS); @(posedge aclk); chk(irq, 1'b0);
      pulse(8, 1'b1); chk(rts_n, 1'b1);
      pulse(1, 1'b1); chk(rts_n, 1'b0);
   endtask
   task automatic auto_cts;
      wr(ufc_pkg::UFC_EFR_OFS, 8'h80); cts_n <= 1'b1; repeat (4) @(posedge aclk);
      chk(tx_allow, 1'b0);
      chk(irq, 1'b1);
      rd(ufc_pkg::UFC_FSR_OFS); chk(rv[1], 1'b1);
      cts_n <= 1'b0; repeat (4) @(posedge aclk); chk(tx_allow, 1'b1);
   endtask
   task automatic soft_tx;
      wr(ufc_pkg::UFC_XON1_OFS, 8'h11); wr(ufc_pkg::UFC_XOFF1_OFS, 8'h13); wr(ufc_pkg::UFC_EFR_OFS, 8'h08);
      pulse(9, 1'b0); chk(last_char, 8'h13);
      pulse(9, 1'b1); chk(last_char, 8'h11);
   endtask
   task automatic rx_in(input logic [7:0] c);
      rx_char <= c; rx_char_valid <= 1'b1; @(posedge aclk);
      rx_char_valid <= 1'b0; repeat (4) @(posedge aclk);
   endtask
   task automatic soft_rx;
      wr(ufc_pkg::UFC_EFR_OFS, 8'h02);
      rx_in(8'h13); chk(tx_allow, 1'b0);
      rd(ufc_pkg::UFC_FSR_OFS); chk(rv[0], 1'b1);
      chk(seen, 3'h4);
      rx_in(8'h11); chk(tx_allow, 1'b1);
   endtask
   task automatic overrun;
      wr(ufc_pkg::UFC_EFR_OFS, 8'h00); wr(ufc_pkg::UFC_FCR_OFS, 8'h00);
      pulse(2, 1'b0); chk(seen, 3'h7);
      rd(ufc_pkg::UFC_RCR_OFS); chk(rv, 32'h1);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      thresholds();
      auto_rts();
      auto_cts();
      soft_tx();
      soft_rx();
      overrun();
      finish_test();
   end
   initial begin
      #50000;
      n_fail++;
      finish_test();
   end
endmodule // tb

/* File: test/ufc_remote.sv */
// far-end model: remote uart taking xon/xoff characters
// assumes one clock shared with the flow control unit
`timescale 1ns/10ps
module ufc_remote (
   input wire logic aclk,
   input wire logic xchar_valid,
   input wire logic [7:0] xchar_data,
   output logic xchar_ready,
   output logic [7:0] last_char
);
   // ****************************************
   // slow acceptor
   // ****************************************
   initial begin
      xchar_ready = 1'b0;
      last_char = 8'h00;
   end
   // takes a character only every other cycle, stalling the sender
   always @(posedge aclk) begin
      if (xchar_valid && xchar_ready) last_char <= xchar_data;
      xchar_ready <= ~xchar_ready;
   end
endmodule // ufc_remote
